// file: rtl/eeprom_ctrl_config_protect.sv
// Purpose: clock divider, interrupt enables and array protection for the emulated EEPROM
// Assumes: classic Wishbone slave, byte lane 0 carries the 8-bit registers
// Notes:   one clock, CE low freezes every flip-flop including the bus answer
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps

// Notes on behaviour
// - divider loaded flag, bit 7, read-only, set by first divider write.
// - divider bits 6..0 take only the first write after reset.
// - prescale_by_eight divides oscillator by 8 ahead of the divider.
// - prescaler and divider together reach a ratio of 512.
// - both factory test registers read zero and ignore writes.
// - two interrupt enables read/write, bits 5..0 read zero.
// - buffer-empty flag with its enable requests an interrupt.
// - command-complete flag with its enable requests an interrupt.
// - protection register loads the nonvolatile byte during reset.
// - user nonvolatile flags 6..4 read back loaded value, ignore writes.
// - array_open and range_protect_disable may only be written to 0.
// - size field writable only while range_protect_disable is 1.
// - array_open 0 protects the whole array.
// - range_protect_disable 0 enables top-sector protection when array open.
// - protected sector ends 0x0FFF, size (select+1) times 64 bytes.
// - program or erase to protected address refused, violation flag set.
// - mass erase only with open and disable both 1, else violation.
// - buffer-empty flag shows empty buffers, cleared by writing 1.
// - command-complete clears with buffer-empty, sets when all commands finish.
// - while violation flag set no command launches.
module eeprom_ctrl_config_protect #(
   parameter int ADDR_W = 8
) (
   // clock, reset, enable
   input  wire logic                 CLK,
   input  wire logic                 SRST,
   input  wire logic                 CE,
   // wishbone slave
   input  wire logic                 WB_CYC_I,
   input  wire logic                 WB_STB_I,
   input  wire logic                 WB_WE_I,
   input  wire logic [ADDR_W-1:0]    WB_ADR_I,
   input  wire logic [3:0]           WB_SEL_I,
   input  wire logic [31:0]          WB_DAT_I,
   output logic      [31:0]          WB_DAT_O,
   output logic                      WB_ACK_O,
   // array and sequencer
   input  wire logic [7:0]           NV_PROT_BYTE,
   input  wire logic                 CMD_VALID,
   input  wire eectl_pkg::cmd_req_t  CMD_REQ,
   input  wire eectl_pkg::seq_evt_t  SEQ_EVT,
   output logic                      CMD_LAUNCH,
   output logic                      CMD_REFUSED,
   output logic                      TIMER_TICK,
   // interrupt
   output logic                      IRQ
);
   import eectl_pkg::*;

   // ********************************************************
   // elaboration checks
   // ********************************************************
   generate
      // the upper-bit decode needs at least one bit above the 6-bit register window
      if (ADDR_W < 7 || ADDR_W > 16) begin : g_bad_addr
         $error("ADDR_W must lie between 7 and 16");
      end
   endgenerate

   // ********************************************************
   // bus decode
   // ********************************************************
   logic              ack_r;
   logic [31:0]       rdat_r;
   logic              req;
   logic              wr;
   logic [3:0]        idx;
   logic              mapped;
   logic [7:0]        wbyte;

   assign req    = WB_CYC_I & WB_STB_I & ~ack_r;
   assign wr     = req & WB_WE_I & WB_SEL_I[0];
   assign idx    = WB_ADR_I[5:2];
   assign mapped = (WB_ADR_I[1:0] == 2'h0) && (idx <= IDX_STATUS)
                   && (WB_ADR_I[ADDR_W-1:6] == '0);
   assign wbyte  = WB_DAT_I[7:0];

   // ********************************************************
   // register state
   // ********************************************************
   logic              loaded_r;
   logic [6:0]        div_r;
   logic              be_en_r;
   logic              cc_en_r;
   logic              open_r;
   logic [2:0]        nv_r;
   logic              dis_r;
   logic [2:0]        size_r;
   logic              be_r;
   logic              cc_r;
   logic              pv_r;
   logic              irq_r;
   logic              launch_r;
   logic              refused_r;
   logic              tick_r;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         loaded_r <= 1'b0;
         div_r    <= DIV_RESET;
      end else if (CE && wr && mapped && idx == IDX_CLKDIV && !loaded_r) begin
         loaded_r <= 1'b1;
         div_r    <= wbyte[6:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         {be_en_r, cc_en_r} <= IRQCFG_RESET;
      end else if (CE && wr && mapped && idx == IDX_IRQCFG) begin
         be_en_r <= wbyte[BIT_BE_IRQ_EN];
         cc_en_r <= wbyte[BIT_CC_IRQ_EN];
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         open_r <= NV_PROT_BYTE[BIT_ARRAY_OPEN];
         nv_r   <= NV_PROT_BYTE[BIT_NV_HI:BIT_NV_LO];
         dis_r  <= NV_PROT_BYTE[BIT_RANGE_DIS];
         size_r <= NV_PROT_BYTE[BIT_SIZE_HI:0];
      end else if (CE && wr && mapped && idx == IDX_PROT) begin
         open_r <= open_r & wbyte[BIT_ARRAY_OPEN];
         dis_r  <= dis_r & wbyte[BIT_RANGE_DIS];
         if (dis_r) begin
            size_r <= wbyte[BIT_SIZE_HI:0];
         end
      end
   end

   // ********************************************************
   // protection check
   // ********************************************************
   logic              in_sector;
   logic              addr_prot;
   logic              refuse;
   logic              st_wr;

   // sector from 0x1000 - (size+1)*64 to 0x0FFF
   assign in_sector = (CMD_REQ.addr[11:9] == TOP_BLOCK) && (CMD_REQ.addr[8:6] >= ~size_r);
   // range protection when disable is 0
   assign addr_prot = !open_r || (!dis_r && in_sector);
   assign refuse    = CMD_REQ.alters && (CMD_REQ.mass ? !(open_r && dis_r) : addr_prot);
   assign st_wr     = wr && mapped && idx == IDX_STATUS;

   // ********************************************************
   // status flags, set wins over clear
   // ********************************************************
   // set by sequencer, write 1 clears
   always_ff @(posedge CLK) begin
      if (SRST) begin
         be_r <= 1'b1;
      end else if (CE) begin
         if (SEQ_EVT.buf_empty) begin
            be_r <= 1'b1;
         end else if (st_wr && wbyte[BIT_BUF_EMPTY]) begin
            be_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         cc_r <= 1'b1;
      end else if (CE) begin
         if (SEQ_EVT.all_done) begin
            cc_r <= 1'b1;
         end else if (st_wr && wbyte[BIT_BUF_EMPTY] && !SEQ_EVT.buf_empty) begin
            // buffer-empty set wins, so its clear did not happen: keep complete too
            cc_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         pv_r <= 1'b0;
      end else if (CE) begin
         if (CMD_VALID && refuse) begin
            pv_r <= 1'b1;
         end else if (st_wr && wbyte[BIT_PROT_VIOL]) begin
            pv_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         launch_r  <= 1'b0;
         refused_r <= 1'b0;
      end else if (CE) begin
         launch_r  <= CMD_VALID && !refuse && !pv_r;
         refused_r <= CMD_VALID && (refuse || pv_r);
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         irq_r <= 1'b0;
      end else if (CE) begin
         irq_r <= (be_r && be_en_r) || (cc_r && cc_en_r);
      end
   end

   // ********************************************************
   // timing clock divider
   // ********************************************************
   logic [2:0]        pre_cnt_r;
   logic [5:0]        div_cnt_r;
   logic              pre_tick;

   // optional divide by 8 ahead of the divider
   assign pre_tick = !div_r[BIT_PRESCALE8] || (pre_cnt_r == PRESCALE_LAST);

   // ratio (value+1), times 8 with prescale_by_eight, reaches 512
   // divider idles until loaded so no tick runs at an unknown rate
   always_ff @(posedge CLK) begin
      if (SRST) begin
         pre_cnt_r <= 3'h0;
         div_cnt_r <= 6'h00;
         tick_r    <= 1'b0;
      end else if (CE) begin
         tick_r <= 1'b0;
         if (loaded_r) begin
            pre_cnt_r <= pre_tick ? 3'h0 : pre_cnt_r + 3'h1;
            if (pre_tick) begin
               if (div_cnt_r == div_r[5:0]) begin
                  div_cnt_r <= 6'h00;
                  tick_r    <= 1'b1;
               end else begin
                  div_cnt_r <= div_cnt_r + 6'h01;
               end
            end
         end
      end
   end

   // ********************************************************
   // bus answer
   // ********************************************************
   // test registers and unmapped read zero
   always_ff @(posedge CLK) begin
      if (SRST) begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end else if (CE) begin
         ack_r  <= req;
         rdat_r <= 32'h0000_0000;
         if (req && !WB_WE_I && mapped) begin
            case (idx)
               IDX_CLKDIV: rdat_r[7:0] <= {loaded_r, div_r};
               IDX_IRQCFG: rdat_r[7:0] <= {be_en_r, cc_en_r, 6'h00};
               IDX_PROT:   rdat_r[7:0] <= {open_r, nv_r, dis_r, size_r};
               IDX_STATUS: rdat_r[7:0] <= {be_r, cc_r, pv_r, 5'h00};
               default:    rdat_r      <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign WB_ACK_O    = ack_r;
   assign WB_DAT_O    = rdat_r;
   assign IRQ         = irq_r;
   assign CMD_LAUNCH  = launch_r;
   assign CMD_REFUSED = refused_r;
   assign TIMER_TICK  = tick_r;

   // ********************************************************
   // checks
   // ********************************************************
   logic [9:0]        gap_r;
   logic              gap_ok_r;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         gap_r    <= 10'h000;
         gap_ok_r <= 1'b0;
      end else if (CE) begin
         gap_r <= tick_r ? 10'h001 : gap_r + 10'h001;
         if (tick_r) begin
            gap_ok_r <= 1'b1;
         end
      end
   end

   sequence s_read(logic [3:0] i);
      req && !WB_WE_I && mapped && idx == i;
   endsequence

   sequence s_answer;
      ack_r ##1 !ack_r;
   endsequence

   property p_loaded_sticky;
      @(posedge CLK) disable iff (SRST || !CE) loaded_r |=> loaded_r;
   endproperty
   a_loaded_sticky: assert property (p_loaded_sticky) else $error("divider lock dropped");

   property p_div_once;
      @(posedge CLK) disable iff (SRST || !CE)
         (loaded_r && wr && idx == IDX_CLKDIV) |=> $stable(div_r) && loaded_r;
   endproperty
   a_div_once: assert property (p_div_once) else $error("divider rewritten");

   property p_tick_ratio;
      @(posedge CLK) disable iff (SRST || !CE)
         (tick_r && gap_ok_r && $stable(div_r)) |->
         gap_r == ({4'h0, div_r[5:0]} + 10'h001) * (div_r[6] ? 10'h008 : 10'h001);
   endproperty
   a_tick_ratio: assert property (p_tick_ratio) else $error("timing tick period wrong");

   property p_test_zero;
      @(posedge CLK) disable iff (SRST || !CE)
         (s_read(IDX_TESTA) or s_read(IDX_TESTB)) |=> WB_DAT_O == 32'h0000_0000;
   endproperty
   a_test_zero: assert property (p_test_zero) else $error("test register not zero");

   property p_cfg_read;
      @(posedge CLK) disable iff (SRST || !CE)
         s_read(IDX_IRQCFG) |=> WB_DAT_O == {24'h00_0000, $past(be_en_r), $past(cc_en_r), 6'h00};
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("irq config readback wrong");

   property p_irq;
      @(posedge CLK) disable iff (SRST || !CE)
         1'b1 |=> IRQ == $past((be_r && be_en_r) || (cc_r && cc_en_r));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt output wrong");

   property p_nv_ro;
      @(posedge CLK) disable iff (SRST || !CE) 1'b1 |=> $stable(nv_r);
   endproperty
   a_nv_ro: assert property (p_nv_ro) else $error("nonvolatile flags changed");

   property p_only_down;
      @(posedge CLK) disable iff (SRST || !CE) !$rose(open_r) && !$rose(dis_r);
   endproperty
   a_only_down: assert property (p_only_down) else $error("protection bit raised");

   property p_size_lock;
      @(posedge CLK) disable iff (SRST || !CE) !dis_r |=> $stable(size_r);
   endproperty
   a_size_lock: assert property (p_size_lock) else $error("size changed while locked");

   property p_refuse;
      @(posedge CLK) disable iff (SRST || !CE)
         (CMD_VALID && refuse) |=> pv_r && !CMD_LAUNCH && CMD_REFUSED;
   endproperty
   a_refuse: assert property (p_refuse) else $error("protected command not refused");

   property p_pv_block;
      @(posedge CLK) disable iff (SRST || !CE) (CMD_VALID && pv_r) |=> !CMD_LAUNCH;
   endproperty
   a_pv_block: assert property (p_pv_block) else $error("launch during violation");

   property p_cc_clear;
      @(posedge CLK) disable iff (SRST || !CE)
         (st_wr && wbyte[BIT_BUF_EMPTY] && !SEQ_EVT.all_done && !SEQ_EVT.buf_empty)
         |=> !cc_r && !be_r;
   endproperty
   a_cc_clear: assert property (p_cc_clear) else $error("flags not cleared together");

   property p_bus;
      @(posedge CLK) disable iff (SRST || !CE) req |=> s_answer;
   endproperty
   a_bus: assert property (p_bus) else $error("bus answer not one cycle");
endmodule

// file: rtl/eectl_pkg.sv
// Purpose: shared constants and carrier types of the nonvolatile config/protect block
// Assumes: registers one aligned 32-bit word each, byte address = 4 * index
// Notes:   oscillator clock is the block clock CLK (20 MHz)
package eectl_pkg;
   // ********************************************************
   // register indices (byte address is four times the index)
   // ********************************************************
   localparam logic [3:0] IDX_CLKDIV = 4'h0;
   localparam logic [3:0] IDX_TESTA  = 4'h1;
   localparam logic [3:0] IDX_TESTB  = 4'h2;
   localparam logic [3:0] IDX_IRQCFG = 4'h3;
   localparam logic [3:0] IDX_PROT   = 4'h4;
   localparam logic [3:0] IDX_STATUS = 4'h5;
   // ********************************************************
   // field positions
   // ********************************************************
   localparam int BIT_DIV_LOADED  = 7;
   localparam int BIT_PRESCALE8   = 6;
   localparam int BIT_BE_IRQ_EN   = 7;
   localparam int BIT_CC_IRQ_EN   = 6;
   localparam int BIT_ARRAY_OPEN  = 7;
   localparam int BIT_NV_HI       = 6;
   localparam int BIT_NV_LO       = 4;
   localparam int BIT_RANGE_DIS   = 3;
   localparam int BIT_SIZE_HI     = 2;
   localparam int BIT_BUF_EMPTY   = 7;
   localparam int BIT_CMD_DONE    = 6;
   localparam int BIT_PROT_VIOL   = 5;
   // ********************************************************
   // reset values and counts
   // ********************************************************
   localparam logic [6:0] DIV_RESET      = 7'h00;
   localparam logic [1:0] IRQCFG_RESET   = 2'h0;
   localparam logic [2:0] PRESCALE_LAST  = 3'h7;   // divide by 8
   localparam logic [2:0] TOP_BLOCK      = 3'h7;   // address bits 11:9 of 0x0E00 upward
   localparam int         CLK_HZ         = 20_000_000;
   localparam int         MAX_DIV_RATIO  = 512;
   localparam logic [11:0] NV_PROT_ADDR  = 12'h0FFD;

   // command offered by the sequencer, checked before launch
   typedef struct packed {
      logic        alters;   // program or erase
      logic        mass;     // mass erase
      logic [11:0] addr;
   } cmd_req_t;

   // events reported by the sequencer
   typedef struct packed {
      logic buf_empty;       // buffers drained, new sequence may start
      logic all_done;        // every active and pending command finished
   } seq_evt_t;
endpackage

// file: dv/nv_array_model.sv
// Purpose: behavioural array and command sequencer beside the config/protect block
// Assumes: one clock, every request launched just after a rising edge
// Notes:   the protection byte changes only through program_prot
`timescale 1ns/10ps
module nv_array_model (
   // clock
   input  wire logic                 clk,
   // toward the block
   output logic [7:0]                nv_prot_byte,
   output logic                      cmd_valid,
   output eectl_pkg::cmd_req_t       cmd_req,
   output eectl_pkg::seq_evt_t       seq_evt,
   // verdict from the block
   input  wire logic                 cmd_launch,
   input  wire logic                 cmd_refused
);
   import eectl_pkg::*;
   logic [7:0] prot_byte_r;
   assign nv_prot_byte = prot_byte_r;
   initial begin
      prot_byte_r = 8'hFF;
      cmd_valid   = 1'b0;
      cmd_req     = '0;
      seq_evt     = '0;
   end
   task automatic program_prot(input logic [7:0] b);
      prot_byte_r <= b;
   endtask
   task automatic offer(input logic alt, input logic ms, input logic [11:0] a,
                        output logic launched, output logic refused);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_req   <= '{alters: alt, mass: ms, addr: a};
      @(posedge clk);
      cmd_valid <= 1'b0;
      // stale fields must not look like the last command
      cmd_req   <= cmd_req_t'(~cmd_req);
      @(posedge clk);
      launched = cmd_launch;
      refused  = cmd_refused;
   endtask
   task automatic event_pulse(input logic be, input logic done);
      @(posedge clk);
      seq_evt <= '{buf_empty: be, all_done: done};
      @(posedge clk);
      seq_evt <= '0;
   endtask
endmodule

// file: dv/tb_eeprom_ctrl_config_protect.sv
// Purpose: register, timer, interrupt and protection checks of the config/protect block
// Assumes: classic Wishbone, one 20 MHz clock, clock enable high but for one frozen command
// Notes:   each divider setting needs its own reset because the divider is write-once
`timescale 1ns/10ps
module tb_eeprom_ctrl_config_protect;
   import eectl_pkg::*;
   logic        clk;
   logic        srst;
   logic        ce;
   logic        wb_cyc;
   logic        wb_stb;
   logic        wb_we;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat_w;
   logic [31:0] wb_dat_r;
   logic        wb_ack;
   logic [7:0]  nv_byte;
   logic        cmd_valid;
   cmd_req_t    cmd_req;
   seq_evt_t    seq_evt;
   logic        cmd_launch;
   logic        cmd_refused;
   logic        timer_tick;
   logic        irq;
   int          fail_count = 0;
   int          compares = 0;
   logic [31:0] rd;
   logic        lch;
   logic        rfs;
   int          n;
   logic [7:0]  divs [3] = '{8'h4C, 8'h3F, 8'h7F};
   int          pers [3] = '{104, 64, 512};
   logic [7:0]  dead [3] = '{8'h04, 8'h08, 8'h18};

   eeprom_ctrl_config_protect #(.ADDR_W(8)) i_eeprom_ctrl_config_protect (
      .CLK(clk), .SRST(srst), .CE(ce),
      .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr),
      .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat_w), .WB_DAT_O(wb_dat_r), .WB_ACK_O(wb_ack),
      .NV_PROT_BYTE(nv_byte), .CMD_VALID(cmd_valid), .CMD_REQ(cmd_req),
      .SEQ_EVT(seq_evt), .CMD_LAUNCH(cmd_launch), .CMD_REFUSED(cmd_refused),
      .TIMER_TICK(timer_tick), .IRQ(irq));

   nv_array_model i_nv_array_model (
      .clk(clk), .nv_prot_byte(nv_byte), .cmd_valid(cmd_valid), .cmd_req(cmd_req),
      .seq_evt(seq_evt), .cmd_launch(cmd_launch), .cmd_refused(cmd_refused));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ********************************************************
   // shared tasks
   // ********************************************************
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d);
      int k;
      @(posedge clk);
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_we    <= we;
      wb_adr   <= adr;
      wb_dat_w <= {24'h00_0000, d};
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (wb_ack !== 1'b1 && k < 50);
      if (k >= 50) chk("ack", 32'h0, 32'h1);
      rd = wb_dat_r;
      wb_cyc   <= 1'b0;
      wb_stb   <= 1'b0;
      wb_we    <= 1'b0;
      // released data must not hold its last value
      wb_dat_w <= ~wb_dat_w;
   endtask
   task automatic do_reset();
      srst <= 1'b1;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
   endtask
   task automatic wait_tick(input int lim, output int cnt);
      cnt = 0;
      do begin
         @(posedge clk);
         cnt++;
      end while (timer_tick !== 1'b1 && cnt < lim);
   endtask
   task automatic report_and_stop();
      if (fail_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      #2_000_000;
      fail_count++;
      report_and_stop();
   end

   // ********************************************************
   // main sequence
   // ********************************************************
   initial begin
      srst     = 1'b1;
      ce       = 1'b1;
      wb_cyc   = 1'b0;
      wb_stb   = 1'b0;
      wb_we    = 1'b0;
      wb_adr   = 8'h00;
      wb_sel   = 4'h1;
      wb_dat_w = 32'h0000_0000;
      for (int i = 0; i < 3; i++) begin
         do_reset();
         wb(0, 8'h00, 8'h00);
         chk("clkdiv reset", rd, 32'h0000_0000);
         wait_tick(600, n);
         chk("tick before load", n, 600);
         wb(1, 8'h00, divs[i]);
         wb(1, 8'h00, 8'h05);
         wb(0, 8'h00, 8'h00);
         chk("clkdiv", rd, {24'h00_0000, 1'b1, divs[i][6:0]});
         wait_tick(2000, n);
         wait_tick(2000, n);
         chk("tick period", n, pers[i]);
      end
      wb(0, 8'h10, 8'h00);
      chk("prot load", rd, 32'h0000_00FF);
      foreach (dead[j]) begin
         wb(1, dead[j], 8'hFF);
         wb(0, dead[j], 8'h00);
         chk("test reg", rd, 32'h0000_0000);
      end
      // interrupt enables against the two flags
      wb(1, 8'h0C, 8'h80);
      @(posedge clk);
      chk("irq be", irq, 1'b1);
      wb(1, 8'h0C, 8'h00);
      @(posedge clk);
      chk("irq off", irq, 1'b0);
      wb(1, 8'h14, 8'h80);
      wb(0, 8'h14, 8'h00);
      chk("status w1c", rd, 32'h0000_0000);
      wb(1, 8'h0C, 8'hFF);
      wb(0, 8'h0C, 8'h00);
      chk("irqcfg", rd, 32'h0000_00C0);
      @(posedge clk);
      chk("irq idle", irq, 1'b0);
      i_nv_array_model.event_pulse(1'b0, 1'b1);
      repeat (2) @(posedge clk);
      chk("irq cc", irq, 1'b1);
      wb(1, 8'h0C, 8'h80);
      @(posedge clk);
      chk("irq cc off", irq, 1'b0);
      i_nv_array_model.event_pulse(1'b1, 1'b0);
      repeat (2) @(posedge clk);
      chk("irq be set", irq, 1'b1);
      wb(0, 8'h14, 8'h00);
      chk("status", rd, 32'h0000_00C0);
      // protection gate
      i_nv_array_model.offer(1'b1, 1'b1, 12'h000, lch, rfs);
      chk("mass open", lch, 1'b1);
      wb(1, 8'h10, 8'h82);
      wb(0, 8'h10, 8'h00);
      chk("prot narrow", rd, 32'h0000_00F2);
      wb(1, 8'h10, 8'h8F);
      wb(0, 8'h10, 8'h00);
      chk("prot locked", rd, 32'h0000_00F2);
      i_nv_array_model.offer(1'b1, 1'b0, 12'hF3F, lch, rfs);
      chk("below sector", lch, 1'b1);
      i_nv_array_model.offer(1'b1, 1'b0, 12'hF40, lch, rfs);
      chk("in sector", rfs, 1'b1);
      wb(0, 8'h14, 8'h00);
      chk("violation", rd[5], 1'b1);
      i_nv_array_model.offer(1'b0, 1'b0, 12'h000, lch, rfs);
      chk("blocked", rfs, 1'b1);
      wb(1, 8'h14, 8'h20);
      i_nv_array_model.offer(1'b0, 1'b0, 12'h000, lch, rfs);
      chk("unblocked", lch, 1'b1);
      i_nv_array_model.offer(1'b1, 1'b1, 12'h000, lch, rfs);
      chk("mass ranged", rfs, 1'b1);
      wb(1, 8'h14, 8'h20);
      wb(1, 8'h10, 8'h00);
      wb(0, 8'h10, 8'h00);
      chk("prot closed", rd, 32'h0000_0072);
      i_nv_array_model.offer(1'b1, 1'b0, 12'h000, lch, rfs);
      chk("array closed", rfs, 1'b1);
      wb(1, 8'h14, 8'h20);
      // new protection byte, applied by the next reset
      i_nv_array_model.program_prot(8'h98);
      do_reset();
      wb(0, 8'h10, 8'h00);
      chk("prot reload", rd, 32'h0000_0098);
      wb(0, 8'h00, 8'h00);
      chk("div unlocked", rd, 32'h0000_0000);
      i_nv_array_model.offer(1'b1, 1'b0, 12'hFFF, lch, rfs);
      chk("range off", lch, 1'b1);
      wb(1, 8'h10, 8'h8D);
      wb(0, 8'h10, 8'h00);
      chk("size open", rd, 32'h0000_009D);
      // a command offered while the enable is low must be neither launched nor refused
      ce <= 1'b0;
      i_nv_array_model.offer(1'b1, 1'b0, 12'h000, lch, rfs);
      ce <= 1'b1;
      chk("frozen gate", {lch, rfs}, 32'h0000_0000);
      i_nv_array_model.offer(1'b1, 1'b0, 12'h000, lch, rfs);
      chk("thawed gate", lch, 1'b1);
      report_and_stop();
   end
endmodule
